// File: bench/pec_pulse_src.sv
// Photoelectric switch model that drives pulses onto the counter's input pins.
`timescale 1ns/10ps
module pec_pulse_src (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [4:0] fire_i,
	input wire logic [3:0] width_i,
	output logic [4:0] pins_o,
	output logic busy_o
);
	logic [4:0] cnt_q;
	logic [4:0] mask_q;

	// pulse width control
	// A request starts a high phase of width_i cycles and then a low gap of four cycles.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q <= 5'h00;
			mask_q <= 5'h00;
		end else if (cnt_q == 5'h00 && fire_i != 5'h00) begin
			mask_q <= fire_i;
			cnt_q <= {1'b0, width_i} + 5'h04;
		end else if (cnt_q != 5'h00) begin
			cnt_q <= cnt_q - 5'h01;
		end
	end

	// The switch drives its output low between pulses, so idle pins are a real level.
	assign pins_o = (cnt_q > 5'h04) ? mask_q : 5'h00;
	assign busy_o = (cnt_q != 5'h00);
endmodule : pec_pulse_src

// File: bench/test_pulse_event_counter.sv
// Self-checking testbench for the pulse event counter.
`timescale 1ns/10ps
module test_pulse_event_counter;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h00000000;
	logic [31:0] rdat;
	logic ack;
	logic [4:0] fire = 5'h00;
	logic [3:0] width = 4'h3;
	logic [4:0] pins;
	logic busy;
	logic tr_o;
	logic r1_o;
	logic r2_o;
	int num_errors = 0;
	int n_compared = 0;
	int cycles = 0;

	always #5 clk_i = ~clk_i;

	pec_counter_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
		.digital_input_1_i(pins[0]), .digital_input_2_i(pins[1]), .digital_input_3_i(pins[2]),
		.digital_input_4_i(pins[3]), .fast_pulse_terminal_i(pins[4]), .transistor_output_o(tr_o),
		.relay_output_1_o(r1_o), .relay_output_2_o(r2_o));

	pec_pulse_src u_src (.clk_i(clk_i), .rst_i(rst_i), .fire_i(fire), .width_i(width), .pins_o(pins),
		.busy_o(busy));

	// Prints the verdict and ends the run.
	task finish_test;
		if (num_errors == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : finish_test

	// A hung handshake must not stall the run forever.
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 30000) begin
			num_errors++;
			finish_test();
		end
	end

	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Classic single Wishbone cycle; the request holds until ack is sampled high.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hF;
		wdat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask : wr

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
		logic [31:0] q;
		wb(1'b0, a, 32'h00000000, q);
		check(q & mask, exp);
	endtask : rd_chk

	// One pulse on the pins in mask, then a settle time so the count and outputs have landed.
	task automatic pulse(input logic [4:0] mask, input logic [3:0] w);
		int k;
		@(posedge clk_i);
		fire <= mask;
		width <= w;
		@(posedge clk_i);
		fire <= 5'h00;
		@(posedge clk_i);
		for (k = 0; k < 40 && busy; k++) @(posedge clk_i);
		repeat (3) @(posedge clk_i);
	endtask : pulse

	task t_reset;
		rd_chk(pec_pkg::ADR_CTRL, 32'hFFFFFFFF, 32'h00000000);
		rd_chk(pec_pkg::ADR_INSEL, 32'hFFFFFFFF, 32'h00070401);
		rd_chk(pec_pkg::ADR_FASTSEL, 32'hFFFFFFFF, 32'h00000000);
		rd_chk(pec_pkg::ADR_OUTSEL, 32'hFFFFFFFF, 32'h00050100);
		rd_chk(pec_pkg::ADR_SETCNT, 32'hFFFFFFFF, 32'h00000000);
		rd_chk(pec_pkg::ADR_DESCNT, 32'hFFFFFFFF, 32'h00000000);
		rd_chk(pec_pkg::ADR_COUNT, 32'hFFFFFFFF, 32'h00000000);
		rd_chk(8'h1C, 32'hFFFFFFFF, 32'h00000000);
	endtask : t_reset

	// Every terminal counts once per pulse of width 3 to 11; the fast pin only in digital mode.
	task t_trigger;
		int i;
		wr(pec_pkg::ADR_SETCNT, 32'h0000FFFF);
		wr(pec_pkg::ADR_INSEL, 32'h1F1F1F1F);
		wr(pec_pkg::ADR_FASTSEL, 32'h0000001F);
		pulse(5'h10, 4'h4);
		rd_chk(pec_pkg::ADR_COUNT, 32'h0000FFFF, 32'h00000000);
		wr(pec_pkg::ADR_CTRL, 32'h00000001);
		for (i = 0; i < 5; i++) pulse(5'h01 << i, 4'(3 + 2 * i));
		rd_chk(pec_pkg::ADR_COUNT, 32'h0000FFFF, 32'h00000005);
		pulse(5'h03, 4'h5);
		rd_chk(pec_pkg::ADR_COUNT, 32'h0000FFFF, 32'h00000006);
	endtask : t_trigger

	// Clear input, wrap at the set value and both match outputs.
	task t_wrap;
		int i;
		wr(pec_pkg::ADR_INSEL, 32'h1C00001F);
		pulse(5'h08, 4'h3);
		rd_chk(pec_pkg::ADR_COUNT, 32'h0000FFFF, 32'h00000000);
		wr(pec_pkg::ADR_SETCNT, 32'h00000003);
		wr(pec_pkg::ADR_DESCNT, 32'h00000001);
		wr(pec_pkg::ADR_OUTSEL, 32'h00001312);
		wr(pec_pkg::ADR_COUNT, 32'h0000FFFF);
		rd_chk(pec_pkg::ADR_COUNT, 32'h0000FFFF, 32'h00000000);
		for (i = 1; i < 6; i++) begin
			pulse(5'h01, 4'h4);
			rd_chk(pec_pkg::ADR_COUNT, 32'h0000FFFF, 32'(i % 4));
			check({31'h0, tr_o}, {31'h0, (i % 4) == 3});
			check({31'h0, r1_o}, {31'h0, (i % 4) == 1});
			check({31'h0, r2_o}, 32'h00000000);
		end
	endtask : t_wrap

	// Main sequence: reset for five cycles, then the scenarios.
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_trigger();
		t_wrap();
		finish_test();
	end
endmodule : test_pulse_event_counter

// File: hdl/pec_counter_top.sv
// Pulse event counter with Wishbone register access, input qualification and count-match outputs.
// Notes on behaviour
// - An input whose function code is 31 adds one to the count for each pulse it receives; coincident pulses on several inputs add one in all.
// - An input whose function code is 28 clears the count to zero while it is active; the fast terminal clears only when the fast input type is 1.
// - Trigger pulses may come from any of the four digital inputs or the fast terminal, each by its own code.
// - The fast input type selects pulse input at 0 and digital input at 1, and the fast terminal counts only at 1.
// - The count stays within 0 to 65535 and restarts from zero once it has reached the set counting value.
// - An output whose selection is 18 is on while the count equals the set counting value.
// - An output whose selection is 19 is on while the count equals the designated counting value.
`timescale 1ns/10ps
module pec_counter_top (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [pec_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [pec_pkg::DAT_W-1:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [pec_pkg::DAT_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic digital_input_1_i,
	input wire logic digital_input_2_i,
	input wire logic digital_input_3_i,
	input wire logic digital_input_4_i,
	input wire logic fast_pulse_terminal_i,
	output logic transistor_output_o,
	output logic relay_output_1_o,
	output logic relay_output_2_o
);
	localparam int NI = pec_pkg::N_IN;
	localparam int NO = pec_pkg::N_OUT;
	localparam int SW = pec_pkg::SEL_W;
	localparam int OW = pec_pkg::OUT_W;
	localparam int CW = pec_pkg::CNT_W;

	logic ack_q;
	logic [pec_pkg::DAT_W-1:0] rdata_q;
	logic fast_type_q;
	logic [SW-1:0] in_sel_q [NI];
	logic [OW-1:0] out_sel_q [NO];
	logic [CW-1:0] set_q;
	logic [CW-1:0] des_q;
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic [NO-1:0] out_q;
	logic [NO-1:0] out_w;
	logic [NI-1:0] pins_w;
	logic [NI-1:0] level_w;
	logic [NI-1:0] rise_w;
	logic [NI-1:0] trig_hit;
	logic [NI-1:0] clr_hit;
	logic inc_req;
	logic clr_any;
	logic eq_set;
	logic eq_des;
	logic req;
	logic wr_en;

	assign pins_w = {fast_pulse_terminal_i, digital_input_4_i, digital_input_3_i,
		digital_input_2_i, digital_input_1_i};

	// Bus handshake: one wait state, ack drops in the cycle after it was given.
	assign req = wb_cyc_i & wb_stb_i & ~ack_q;
	assign wr_en = req & wb_we_i;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req;
		end
	end

	// Fast input type; in pulse mode the fast terminal neither counts nor clears.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fast_type_q <= pec_pkg::FAST_TYPE_RST;
		end else if (wr_en && wb_adr_i == pec_pkg::ADR_CTRL && wb_sel_i[0]) begin
			fast_type_q <= wb_dat_i[0];
		end
	end

	// Input function selections: four digital inputs share one word, one byte each.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			in_sel_q[0] <= pec_pkg::IN1_SEL_RST;
			in_sel_q[1] <= pec_pkg::IN2_SEL_RST;
			in_sel_q[2] <= pec_pkg::IN3_SEL_RST;
			in_sel_q[3] <= pec_pkg::IN4_SEL_RST;
			in_sel_q[pec_pkg::FAST_IDX] <= pec_pkg::FAST_SEL_RST;
		end else if (wr_en) begin
			for (int b = 0; b < 4; b++) begin
				if (wb_adr_i == pec_pkg::ADR_INSEL && wb_sel_i[b]) begin
					in_sel_q[b] <= wb_dat_i[b*pec_pkg::FIELD_STRIDE +: SW];
				end
			end
			if (wb_adr_i == pec_pkg::ADR_FASTSEL && wb_sel_i[0]) begin
				in_sel_q[pec_pkg::FAST_IDX] <= wb_dat_i[SW-1:0];
			end
		end
	end

	// Output selections: transistor, relay 1 and relay 2 in bytes 0 to 2.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			out_sel_q[0] <= pec_pkg::TRANS_SEL_RST;
			out_sel_q[1] <= pec_pkg::RELAY1_SEL_RST;
			out_sel_q[2] <= pec_pkg::RELAY2_SEL_RST;
		end else if (wr_en && wb_adr_i == pec_pkg::ADR_OUTSEL) begin
			for (int b = 0; b < NO; b++) begin
				if (wb_sel_i[b]) begin
					out_sel_q[b] <= wb_dat_i[b*pec_pkg::FIELD_STRIDE +: OW];
				end
			end
		end
	end

	// Set and designated counting values; software keeps designated not above set.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			set_q <= pec_pkg::COUNT_RST;
			des_q <= pec_pkg::COUNT_RST;
		end else if (wr_en) begin
			for (int b = 0; b < 2; b++) begin
				if (wb_sel_i[b] && wb_adr_i == pec_pkg::ADR_SETCNT) begin
					set_q[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
				end
				if (wb_sel_i[b] && wb_adr_i == pec_pkg::ADR_DESCNT) begin
					des_q[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
				end
			end
		end
	end

	// Read data is captured with ack; unmapped addresses read zero and ignore writes.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_q <= 32'h00000000;
		end else if (req && !wb_we_i) begin
			case (wb_adr_i)
				pec_pkg::ADR_CTRL: rdata_q <= {31'h00000000, fast_type_q};
				pec_pkg::ADR_INSEL: rdata_q <= {1'b0, in_sel_q[3], 1'b0, in_sel_q[2],
					1'b0, in_sel_q[1], 1'b0, in_sel_q[0]};
				pec_pkg::ADR_FASTSEL: rdata_q <= {25'h0000000, in_sel_q[pec_pkg::FAST_IDX]};
				pec_pkg::ADR_OUTSEL: rdata_q <= {10'h000, out_sel_q[2], 2'h0, out_sel_q[1],
					2'h0, out_sel_q[0]};
				pec_pkg::ADR_SETCNT: rdata_q <= {16'h0000, set_q};
				pec_pkg::ADR_DESCNT: rdata_q <= {16'h0000, des_q};
				pec_pkg::ADR_COUNT: rdata_q <= {11'h000, level_w, cnt_q};
				default: rdata_q <= 32'h00000000;
			endcase
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdata_q;

	// Per terminal: synchronise, then decode the trigger and clear functions.
	for (genvar i = 0; i < NI; i++) begin : g_in
		logic en;
		pec_sync u_sync (
			.clk_i(clk_i),
			.rst_i(rst_i),
			.pin_i(pins_w[i]),
			.level_o(level_w[i]),
			.rise_o(rise_w[i])
		);
		assign en = (i == pec_pkg::FAST_IDX) ? (fast_type_q == pec_pkg::FAST_TYPE_DIGITAL) : 1'b1;
		assign trig_hit[i] = en & rise_w[i] & (in_sel_q[i] == pec_pkg::FUNC_TRIGGER);
		assign clr_hit[i] = en & level_w[i] & (in_sel_q[i] == pec_pkg::FUNC_CLEAR);
	end

	// Coincident edges on several terminals merge into a single count.
	assign inc_req = |trig_hit;
	assign clr_any = |clr_hit;

	// Next count; clear outranks a trigger in the same cycle.
	always_comb begin
		cnt_d = cnt_q;
		if (clr_any) begin
			cnt_d = pec_pkg::COUNT_RST;
		end else if (inc_req) begin
			if (cnt_q >= set_q) begin
				cnt_d = pec_pkg::COUNT_RST;
			end else begin
				cnt_d = cnt_q + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q <= pec_pkg::COUNT_RST;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign eq_set = (cnt_q == set_q);
	assign eq_des = (cnt_q == des_q);

	// Output decoders; the registered stage keeps relay drivers free of decode glitches.
	for (genvar k = 0; k < NO; k++) begin : g_out
		pec_outsel u_outsel (
			.sel_i(out_sel_q[k]),
			.eq_set_i(eq_set),
			.eq_des_i(eq_des),
			.on_o(out_w[k])
		);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			out_q <= 3'h0;
		end else begin
			out_q <= out_w;
		end
	end

	assign transistor_output_o = out_q[0];
	assign relay_output_1_o = out_q[1];
	assign relay_output_2_o = out_q[2];

	// Checks on the counting path and the outputs.
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_trig_in1;
		rise_w[0] && in_sel_q[0] == pec_pkg::FUNC_TRIGGER;
	endsequence

	sequence s_trig_fast;
		rise_w[pec_pkg::FAST_IDX] && in_sel_q[pec_pkg::FAST_IDX] == pec_pkg::FUNC_TRIGGER;
	endsequence

	a_trig_adds_one: assert property (
		s_trig_in1 ##0 (!clr_any && cnt_q < set_q) |=> cnt_q == $past(cnt_q) + 16'h0001)
		else $error("Trigger pulse did not add one to the count.");

	a_clear_zero: assert property (
		clr_any |=> cnt_q == 16'h0000 ##1 (clr_any || cnt_q <= 16'h0001))
		else $error("Clear input did not hold the count at zero.");

	a_any_source: assert property (
		(inc_req && !clr_any && cnt_q < set_q) |=> cnt_q != $past(cnt_q))
		else $error("Trigger from a terminal was not counted.");

	a_fast_gated: assert property (
		s_trig_fast ##0 (!fast_type_q && trig_hit[3:0] == 4'h0 && !clr_any) |=> $stable(cnt_q))
		else $error("Fast terminal counted while in pulse mode.");

	a_wrap_zero: assert property (
		(inc_req && !clr_any && cnt_q >= set_q) |=> cnt_q == 16'h0000)
		else $error("Count did not restart after reaching the set value.");

	a_set_out: assert property (
		(out_sel_q[0] == pec_pkg::OUT_SET_HIT) |=> transistor_output_o == $past(eq_set))
		else $error("Transistor output does not follow the set value match.");

	a_des_out: assert property (
		(out_sel_q[1] == pec_pkg::OUT_DES_HIT) |=> relay_output_1_o == $past(eq_des))
		else $error("Relay output 1 does not follow the designated match.");

	a_one_pulse: assert property (
		rise_w[0] |=> !rise_w[0] [*2])
		else $error("Edge pulse lasted more than one cycle.");

	a_hold_no_count: assert property (
		(!inc_req && !clr_any) |=> $stable(cnt_q))
		else $error("Count moved without a qualified edge.");

	a_set_relay2: assert property (
		(out_sel_q[2] == pec_pkg::OUT_SET_HIT) |=> relay_output_2_o == $past(eq_set))
		else $error("Relay output 2 does not follow the set value match.");

	// Codes that belong to other drive functions must leave the output off.
	a_other_off: assert property (
		(out_sel_q[2] != pec_pkg::OUT_SET_HIT && out_sel_q[2] != pec_pkg::OUT_DES_HIT) |=> !relay_output_2_o)
		else $error("Relay output 2 is on under an unrelated selection.");

	// A pin that sat low for three samples and then stays high for three must give an edge pulse next.
	sequence s_pin_quiet;
		!pins_w[0] [*3];
	endsequence

	sequence s_pin_held;
		pins_w[0] [*3];
	endsequence

	a_edge_latency: assert property (
		s_pin_quiet ##1 s_pin_held |=> rise_w[0])
		else $error("A clean pin pulse did not produce an edge pulse in time.");
endmodule : pec_counter_top

// File: hdl/pec_outsel.sv
// Output function decoder for one transistor or relay output.
`timescale 1ns/10ps
module pec_outsel (
	input wire logic [pec_pkg::OUT_W-1:0] sel_i,
	input wire logic eq_set_i,
	input wire logic eq_des_i,
	output logic on_o
);
	// Codes other than the two count matches belong to other drive functions and read off here.
	always_comb begin
		case (sel_i)
			pec_pkg::OUT_SET_HIT: on_o = eq_set_i;
			pec_pkg::OUT_DES_HIT: on_o = eq_des_i;
			default: on_o = 1'b0;
		endcase
	end
endmodule : pec_outsel

// File: hdl/pec_pkg.sv
// Package with register map, field layout, reset values and function codes of the pulse event counter.
package pec_pkg;
	localparam int ADR_W = 8;
	localparam int DAT_W = 32;
	localparam int CNT_W = 16;
	localparam int SEL_W = 7;
	localparam int OUT_W = 6;
	localparam int N_IN = 5;
	localparam int N_OUT = 3;
	localparam int FAST_IDX = 4;
	localparam int FIELD_STRIDE = 8;
	localparam int LEVEL_LSB = 16;

	// Register byte addresses, one aligned word each.
	localparam logic [ADR_W-1:0] ADR_CTRL = 8'h00;
	localparam logic [ADR_W-1:0] ADR_INSEL = 8'h04;
	localparam logic [ADR_W-1:0] ADR_FASTSEL = 8'h08;
	localparam logic [ADR_W-1:0] ADR_OUTSEL = 8'h0C;
	localparam logic [ADR_W-1:0] ADR_SETCNT = 8'h10;
	localparam logic [ADR_W-1:0] ADR_DESCNT = 8'h14;
	localparam logic [ADR_W-1:0] ADR_COUNT = 8'h18;

	// Input function codes and output selection codes.
	localparam logic [SEL_W-1:0] FUNC_CLEAR = 7'h1C;
	localparam logic [SEL_W-1:0] FUNC_TRIGGER = 7'h1F;
	localparam logic [OUT_W-1:0] OUT_SET_HIT = 6'h12;
	localparam logic [OUT_W-1:0] OUT_DES_HIT = 6'h13;
	localparam logic FAST_TYPE_DIGITAL = 1'b1;

	// Reset values.
	localparam logic FAST_TYPE_RST = 1'b0;
	localparam logic [SEL_W-1:0] IN1_SEL_RST = 7'h01;
	localparam logic [SEL_W-1:0] IN2_SEL_RST = 7'h04;
	localparam logic [SEL_W-1:0] IN3_SEL_RST = 7'h07;
	localparam logic [SEL_W-1:0] IN4_SEL_RST = 7'h00;
	localparam logic [SEL_W-1:0] FAST_SEL_RST = 7'h00;
	localparam logic [OUT_W-1:0] TRANS_SEL_RST = 6'h00;
	localparam logic [OUT_W-1:0] RELAY1_SEL_RST = 6'h01;
	localparam logic [OUT_W-1:0] RELAY2_SEL_RST = 6'h05;
	localparam logic [CNT_W-1:0] COUNT_RST = 16'h0000;
endpackage : pec_pkg

// File: hdl/pec_sync.sv
// Three-stage pin synchroniser with agreement filter and rising-edge pulse.
`timescale 1ns/10ps
module pec_sync (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic pin_i,
	output logic level_o,
	output logic rise_o
);
	logic sync1_q;
	logic sync2_q;
	logic sync3_q;
	logic level_q;

	// Plain shift chain; only the second stage reads the first.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			sync3_q <= 1'b0;
		end else begin
			sync1_q <= pin_i;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	// The level moves only when stages two and three agree, which drops one-cycle glitches.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			level_q <= 1'b0;
		end else if (sync2_q == sync3_q) begin
			level_q <= sync3_q;
		end
	end

	// One-cycle pulse in the cycle before the filtered level rises.
	assign rise_o = sync2_q & sync3_q & ~level_q;
	assign level_o = level_q;
endmodule : pec_sync
